// >>> src/bpf_cfg.svh
/*
  Constants of the bus/port pin function select: widths, address bit
  positions and reset values of the pin-facing flip-flops.
  Assumes it is included by bare name after the package is compiled.
*/
`ifndef BPF_CFG_SVH
`define BPF_CFG_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define BPF_BYTE_W      8
`define BPF_UPPER_W     5
`define BPF_DATA_W      16
`define BPF_ADDR_W      21

// ----------------------------------------------------------------------
// Address and data bit positions on the pin groups
// ----------------------------------------------------------------------
`define BPF_ADDR_LOW_LSB  0
`define BPF_ADDR_MID_LSB  8
`define BPF_ADDR_UP_LSB   16
`define BPF_DATA_HIGH_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BPF_RST_BYTE    8'h00
`define BPF_RST_WORD    16'h0000
`define BPF_RST_BIT     1'b0

`endif

// >>> src/bpf_pkg.sv
/*
  Types of the bus/port pin function select.
  Assumes nothing of its surroundings.
*/
package bpf_pkg;

  typedef logic [7:0]  bpf_byte_t;
  typedef logic [15:0] bpf_word_t;

  // Function that an upper-address pin currently carries
  typedef enum {
    BPF_FN_GPIO,
    BPF_FN_PWM,
    BPF_FN_ADDR
  } bpf_func_e;

endpackage

// >>> src/bpf_pin_mux.sv
/*
  Pin function select for the shared data, address, port and pulse-width
  pins, with pull-up gating. All outputs are registered, so a change of
  mode or data reaches the pins one mclk edge later.
  Assumes the bus controller, port registers and pulse-width channels sit
  in the mclk domain, and that pad cells resolve out/oe/pull-up to a wire.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bpf_cfg.svh"

// Operation
// - Pull-up follows per-pin configuration bit on port input pins only; the code gives middle and upper address pins no pull-up
// - Non-single-chip: low data pins are bus
// - High data pins GPIO unless 16-bit bus
// - High data pins bus only ext 16-bit
// - Low address pins GPIO only single-chip
// - External bus drives low address byte
// - Middle pins: GPIO, or address bits 8-15
// - Upper pins: GPIO, or address bits 16-20
// - Enabled pulse-width channel drives upper pin unless upper pins carry address
module bpf_pin_mux #(
  parameter int UPPER_W = `BPF_UPPER_W
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  // Mode and selection
  input  wire logic              ext_bus_mode,
  input  wire logic              data_bus_16,
  input  wire logic              mid_addr_is_addr,
  input  wire logic              upper_addr_is_addr,
  input  wire logic [UPPER_W-1:0] pwm_pin_en,
  input  wire logic [UPPER_W-1:0] pulse_width_outputs,
  input  wire bpf_pkg::bpf_byte_t pullup_low_data,
  input  wire bpf_pkg::bpf_byte_t pullup_high_data,
  input  wire bpf_pkg::bpf_byte_t pullup_low_addr,
  // Bus controller
  input  wire logic [20:0]       ext_addr,
  input  wire bpf_pkg::bpf_word_t ext_wdata,
  input  wire logic              ext_data_drive,
  output var  bpf_pkg::bpf_word_t ext_rdata,
  // Port registers
  input  wire bpf_pkg::bpf_byte_t low_data_port_out,
  input  wire bpf_pkg::bpf_byte_t low_data_port_dir,
  input  wire bpf_pkg::bpf_byte_t high_data_port_out,
  input  wire bpf_pkg::bpf_byte_t high_data_port_dir,
  input  wire bpf_pkg::bpf_byte_t low_addr_port_out,
  input  wire bpf_pkg::bpf_byte_t low_addr_port_dir,
  input  wire bpf_pkg::bpf_byte_t mid_addr_port_out,
  input  wire bpf_pkg::bpf_byte_t mid_addr_port_dir,
  input  wire logic [UPPER_W-1:0] upper_addr_port_out,
  input  wire logic [UPPER_W-1:0] upper_addr_port_dir,
  output var  bpf_pkg::bpf_byte_t low_data_port_in,
  output var  bpf_pkg::bpf_byte_t high_data_port_in,
  output var  bpf_pkg::bpf_byte_t low_addr_port_in,
  output var  bpf_pkg::bpf_byte_t mid_addr_port_in,
  output var  logic [UPPER_W-1:0] upper_addr_port_in,
  // Pins
  input  wire bpf_pkg::bpf_byte_t low_data_port_pins_in,
  output var  bpf_pkg::bpf_byte_t low_data_port_pins_out,
  output var  bpf_pkg::bpf_byte_t low_data_port_pins_oe,
  output var  bpf_pkg::bpf_byte_t low_data_port_pins_pu,
  input  wire bpf_pkg::bpf_byte_t high_data_port_pins_in,
  output var  bpf_pkg::bpf_byte_t high_data_port_pins_out,
  output var  bpf_pkg::bpf_byte_t high_data_port_pins_oe,
  output var  bpf_pkg::bpf_byte_t high_data_port_pins_pu,
  input  wire bpf_pkg::bpf_byte_t low_addr_port_pins_in,
  output var  bpf_pkg::bpf_byte_t low_addr_port_pins_out,
  output var  bpf_pkg::bpf_byte_t low_addr_port_pins_oe,
  output var  bpf_pkg::bpf_byte_t low_addr_port_pins_pu,
  input  wire bpf_pkg::bpf_byte_t mid_addr_port_pins_in,
  output var  bpf_pkg::bpf_byte_t mid_addr_port_pins_out,
  output var  bpf_pkg::bpf_byte_t mid_addr_port_pins_oe,
  input  wire logic [UPPER_W-1:0] upper_addr_port_pins_in,
  output var  logic [UPPER_W-1:0] upper_addr_port_pins_out,
  output var  logic [UPPER_W-1:0] upper_addr_port_pins_oe
);
  import bpf_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= `BPF_RST_BIT;
      rst_n      <= `BPF_RST_BIT;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------------
  // Group function decode
  // ----------------------------------------------------------------------
  logic high_is_bus;
  logic mid_is_addr;
  logic upper_is_addr;

  assign high_is_bus   = ext_bus_mode && data_bus_16;
  assign mid_is_addr   = ext_bus_mode && mid_addr_is_addr;
  assign upper_is_addr = ext_bus_mode && upper_addr_is_addr;

  // ----------------------------------------------------------------------
  // Byte groups: next values
  // ----------------------------------------------------------------------
  bpf_byte_t next_ld_out, next_ld_oe, next_ld_pu;
  bpf_byte_t next_hd_out, next_hd_oe, next_hd_pu;
  bpf_byte_t next_la_out, next_la_oe, next_la_pu;
  bpf_byte_t next_ma_out, next_ma_oe;
  bpf_word_t next_rdata;
  bpf_byte_t next_ld_in, next_hd_in, next_la_in, next_ma_in;

  always_comb begin
    // Lower data: bus in every non-single-chip mode
    if (ext_bus_mode) begin
      next_ld_out = ext_wdata[`BPF_BYTE_W-1:0];
      next_ld_oe  = {`BPF_BYTE_W{ext_data_drive}};
      next_ld_pu  = `BPF_RST_BYTE;
    end else begin
      next_ld_out = low_data_port_out;
      next_ld_oe  = low_data_port_dir;
      next_ld_pu  = pullup_low_data & ~low_data_port_dir;
    end
    // Upper data: bus only with a 16-bit external bus
    if (high_is_bus) begin
      next_hd_out = ext_wdata[`BPF_DATA_HIGH_LSB +: `BPF_BYTE_W];
      next_hd_oe  = {`BPF_BYTE_W{ext_data_drive}};
      next_hd_pu  = `BPF_RST_BYTE;
    end else begin
      next_hd_out = high_data_port_out;
      next_hd_oe  = high_data_port_dir;
      next_hd_pu  = pullup_high_data & ~high_data_port_dir;
    end
    // Lower address: output-only address in external-bus mode
    if (ext_bus_mode) begin
      next_la_out = ext_addr[`BPF_ADDR_LOW_LSB +: `BPF_BYTE_W];
      next_la_oe  = 8'hFF;
      next_la_pu  = `BPF_RST_BYTE;
    end else begin
      next_la_out = low_addr_port_out;
      next_la_oe  = low_addr_port_dir;
      next_la_pu  = pullup_low_addr & ~low_addr_port_dir;
    end
    // Middle address
    if (mid_is_addr) begin
      next_ma_out = ext_addr[`BPF_ADDR_MID_LSB +: `BPF_BYTE_W];
      next_ma_oe  = 8'hFF;
    end else begin
      next_ma_out = mid_addr_port_out;
      next_ma_oe  = mid_addr_port_dir;
    end
    // Readback: the bus sees its data pins, ports see every pin level.
    // With an 8-bit bus the upper byte reads as zero.
    next_rdata = {high_is_bus ? high_data_port_pins_in : `BPF_RST_BYTE,
                  ext_bus_mode ? low_data_port_pins_in : `BPF_RST_BYTE};
    next_ld_in = low_data_port_pins_in;
    next_hd_in = high_data_port_pins_in;
    next_la_in = low_addr_port_pins_in;
    next_ma_in = mid_addr_port_pins_in;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_data_port_pins_out  <= `BPF_RST_BYTE;
      low_data_port_pins_oe   <= `BPF_RST_BYTE;
      low_data_port_pins_pu   <= `BPF_RST_BYTE;
      high_data_port_pins_out <= `BPF_RST_BYTE;
      high_data_port_pins_oe  <= `BPF_RST_BYTE;
      high_data_port_pins_pu  <= `BPF_RST_BYTE;
      low_addr_port_pins_out  <= `BPF_RST_BYTE;
      low_addr_port_pins_oe   <= `BPF_RST_BYTE;
      low_addr_port_pins_pu   <= `BPF_RST_BYTE;
      mid_addr_port_pins_out  <= `BPF_RST_BYTE;
      mid_addr_port_pins_oe   <= `BPF_RST_BYTE;
      ext_rdata               <= `BPF_RST_WORD;
      low_data_port_in        <= `BPF_RST_BYTE;
      high_data_port_in       <= `BPF_RST_BYTE;
      low_addr_port_in        <= `BPF_RST_BYTE;
      mid_addr_port_in        <= `BPF_RST_BYTE;
    end else begin
      low_data_port_pins_out  <= next_ld_out;
      low_data_port_pins_oe   <= next_ld_oe;
      low_data_port_pins_pu   <= next_ld_pu;
      high_data_port_pins_out <= next_hd_out;
      high_data_port_pins_oe  <= next_hd_oe;
      high_data_port_pins_pu  <= next_hd_pu;
      low_addr_port_pins_out  <= next_la_out;
      low_addr_port_pins_oe   <= next_la_oe;
      low_addr_port_pins_pu   <= next_la_pu;
      mid_addr_port_pins_out  <= next_ma_out;
      mid_addr_port_pins_oe   <= next_ma_oe;
      ext_rdata               <= next_rdata;
      low_data_port_in        <= next_ld_in;
      high_data_port_in       <= next_hd_in;
      low_addr_port_in        <= next_la_in;
      mid_addr_port_in        <= next_ma_in;
    end
  end

  // ----------------------------------------------------------------------
  // Upper address pins, one slice per pin
  // ----------------------------------------------------------------------
  logic [UPPER_W-1:0] next_up_out;
  logic [UPPER_W-1:0] next_up_oe;
  logic [UPPER_W-1:0] next_up_in;

  genvar gi;
  generate
    for (gi = 0; gi < UPPER_W; gi++) begin : g_upper
      bpf_func_e func;
      // Address beats the pulse channel, which beats the port
      assign func = upper_is_addr  ? BPF_FN_ADDR :
                    pwm_pin_en[gi] ? BPF_FN_PWM  : BPF_FN_GPIO;
      assign next_up_out[gi] = (func == BPF_FN_ADDR) ? ext_addr[`BPF_ADDR_UP_LSB + gi] :
                               (func == BPF_FN_PWM)  ? pulse_width_outputs[gi] :
                                                       upper_addr_port_out[gi];
      assign next_up_oe[gi]  = (func == BPF_FN_GPIO) ? upper_addr_port_dir[gi] : 1'b1;
      assign next_up_in[gi]  = upper_addr_port_pins_in[gi];
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upper_addr_port_pins_out <= '0;
      upper_addr_port_pins_oe  <= '0;
      upper_addr_port_in       <= '0;
    end else begin
      upper_addr_port_pins_out <= next_up_out;
      upper_addr_port_pins_oe  <= next_up_oe;
      upper_addr_port_in       <= next_up_in;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/bpf_pin_mux_props.sv
/* Assertions on the ports of the pin function select.
   Assumes one mclk domain and outputs one edge behind their inputs. */
`timescale 1ns/1ns
`default_nettype none
module bpf_pin_mux_props #(parameter int UPPER_W = 5) (
  input wire logic                mclk, reset_n, ext_bus_mode, data_bus_16,
  input wire logic                mid_addr_is_addr, upper_addr_is_addr, ext_data_drive,
  input wire logic [UPPER_W-1:0]  pwm_pin_en, pulse_width_outputs,
  input wire logic [UPPER_W-1:0]  upper_addr_port_pins_out, upper_addr_port_pins_oe,
  input wire logic [20:0]         ext_addr,
  input wire bpf_pkg::bpf_word_t  ext_wdata,
  input wire bpf_pkg::bpf_byte_t  pullup_low_data, low_data_port_dir, high_data_port_dir,
  input wire bpf_pkg::bpf_byte_t  low_addr_port_dir, mid_addr_port_pins_oe,
  input wire bpf_pkg::bpf_byte_t  low_data_port_pins_out, low_data_port_pins_oe,
  input wire bpf_pkg::bpf_byte_t  low_data_port_pins_pu, high_data_port_pins_out,
  input wire bpf_pkg::bpf_byte_t  high_data_port_pins_oe, low_addr_port_pins_out,
  input wire bpf_pkg::bpf_byte_t  low_addr_port_pins_oe, mid_addr_port_pins_out
);
  logic [1:0] n_up;
  logic       ok;
  assign ok = (n_up == 2'h3);
  // Two synchroniser edges plus one load edge before outputs mean anything
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) n_up <= 2'h0;
    else if (!ok) n_up <= n_up + 2'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  low_data_bus_a: assert property (ok && $past(ext_bus_mode) && $past(ext_data_drive) |->
    low_data_port_pins_oe == 8'hFF && low_data_port_pins_out == $past(ext_wdata[7:0]))
    else $error("low data pins not carrying write data");
  high_data_gpio_a: assert property (ok && !($past(ext_bus_mode) && $past(data_bus_16)) |->
    high_data_port_pins_oe == $past(high_data_port_dir)) else $error("high data pins left port");
  high_data_bus_a: assert property (ok && $past(ext_bus_mode) && $past(data_bus_16)
    && $past(ext_data_drive) |-> high_data_port_pins_out == $past(ext_wdata[15:8]))
    else $error("high data pins not carrying write data");
  low_addr_port_a: assert property (ok && !$past(ext_bus_mode) |->
    low_addr_port_pins_oe == $past(low_addr_port_dir)) else $error("low address pins not port");
  low_addr_bus_a: assert property (ok && $past(ext_bus_mode) |-> low_addr_port_pins_oe == 8'hFF
    && low_addr_port_pins_out == $past(ext_addr[7:0])) else $error("low address byte wrong");
  mid_addr_bus_a: assert property (ok && $past(ext_bus_mode) && $past(mid_addr_is_addr) |->
    mid_addr_port_pins_oe == 8'hFF && mid_addr_port_pins_out == $past(ext_addr[15:8]))
    else $error("middle address byte wrong");
  upper_addr_a: assert property (ok && $past(ext_bus_mode) && $past(upper_addr_is_addr) |->
    upper_addr_port_pins_out == UPPER_W'($past(ext_addr) >> 16) && upper_addr_port_pins_oe == '1)
    else $error("upper address bits wrong");
  pulse_pin_a: assert property (ok && !($past(ext_bus_mode) && $past(upper_addr_is_addr)) |->
    ((upper_addr_port_pins_out ^ $past(pulse_width_outputs)) & $past(pwm_pin_en)) == '0
    && (upper_addr_port_pins_oe & $past(pwm_pin_en)) == $past(pwm_pin_en))
    else $error("pulse channel not on its pin");
  pullup_gate_a: assert property (ok |-> low_data_port_pins_pu == ($past(ext_bus_mode) ? 8'h00
    : $past(pullup_low_data) & ~$past(low_data_port_dir))) else $error("pull-up gating wrong");

  cover property (ok && ext_bus_mode && data_bus_16 && !ext_data_drive);
  cover property (ok && !ext_bus_mode && |pwm_pin_en);
  cover property (ok && ext_bus_mode && upper_addr_is_addr && |pwm_pin_en);
endmodule
bind bpf_pin_mux bpf_pin_mux_props #(.UPPER_W(UPPER_W)) i_props (.*);
`default_nettype wire

// >>> testbench/bpf_ext_mem.sv
/* External memory model on the 16 data pins.
   Assumes the bench tells it when a read is answered. */
`timescale 1ns/1ns
`default_nettype none
module bpf_ext_mem (
  input  wire logic        mclk,
  input  wire logic [15:0] pin_out, pin_oe, rd_val,
  input  wire logic        rd_en,
  output logic      [15:0] pin_lvl
);
  logic [15:0] last = 16'h0000;
  // Undriven lines flip every cycle unless rd_en answers a read, so a stale level never passes for data
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : (rd_en ? rd_val[i] : ~last[i]);
    end
  end
  always_ff @(posedge mclk) last <= pin_lvl;
endmodule
`default_nettype wire

// >>> testbench/tb_bpf_pin_mux.sv
/* Directed bench for the pin function select with an external memory model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ns
`default_nettype none
module tb_bpf_pin_mux;
  import bpf_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0, ext_bus_mode, data_bus_16, mid_addr_is_addr;
  logic upper_addr_is_addr, ext_data_drive, rd_en;
  logic [4:0] pwm_pin_en, pulse_width_outputs, upper_addr_port_out, upper_addr_port_dir;
  logic [4:0] upper_addr_port_in, upper_addr_port_pins_in, upper_addr_port_pins_out;
  logic [4:0] upper_addr_port_pins_oe;
  logic [20:0] ext_addr;
  bpf_word_t ext_wdata, ext_rdata, rd_val, data_lvl;
  bpf_byte_t pullup_low_data, pullup_high_data, pullup_low_addr, low_data_port_out;
  bpf_byte_t low_data_port_dir, high_data_port_out, high_data_port_dir, low_addr_port_out;
  bpf_byte_t low_addr_port_dir, mid_addr_port_out, mid_addr_port_dir, low_data_port_in;
  bpf_byte_t high_data_port_in, low_addr_port_in, mid_addr_port_in, la_ext;
  bpf_byte_t low_data_port_pins_in, low_data_port_pins_out, low_data_port_pins_oe;
  bpf_byte_t low_data_port_pins_pu, high_data_port_pins_in, high_data_port_pins_out;
  bpf_byte_t high_data_port_pins_oe, high_data_port_pins_pu, low_addr_port_pins_in;
  bpf_byte_t low_addr_port_pins_out, low_addr_port_pins_oe, low_addr_port_pins_pu;
  bpf_byte_t mid_addr_port_pins_in, mid_addr_port_pins_out, mid_addr_port_pins_oe;
  int n_fail = 0, total_checks = 0;

  always #2 mclk = ~mclk;
  bpf_pin_mux i_dut (.*);
  bpf_ext_mem i_mem (.mclk(mclk), .pin_out({high_data_port_pins_out, low_data_port_pins_out}),
    .pin_oe({high_data_port_pins_oe, low_data_port_pins_oe}), .rd_val(rd_val), .rd_en(rd_en),
    .pin_lvl(data_lvl));
  assign {high_data_port_pins_in, low_data_port_pins_in} = data_lvl;
  assign low_addr_port_pins_in = (low_addr_port_pins_oe & low_addr_port_pins_out)
    | (~low_addr_port_pins_oe & la_ext);
  assign mid_addr_port_pins_in = mid_addr_port_pins_out;
  assign upper_addr_port_pins_in = upper_addr_port_pins_out;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic mode(input logic ext, b16, mid, up, drv);
    @(posedge mclk);
    {ext_bus_mode, data_bus_16, mid_addr_is_addr, upper_addr_is_addr, ext_data_drive}
      <= {ext, b16, mid, up, drv};
  endtask
  // Outputs lag one edge; sample just after the next one
  task automatic settle;
    @(posedge mclk);
    #1;
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    {ext_bus_mode, data_bus_16, mid_addr_is_addr, upper_addr_is_addr, ext_data_drive} = '0;
    {rd_en, pwm_pin_en, pulse_width_outputs, ext_addr, rd_val} = '0;
    // Mixed pull-up bits, so that a design ignoring the configuration shows up
    {pullup_low_data, pullup_high_data, pullup_low_addr} = 24'h7E3CA5;
    {low_data_port_out, low_data_port_dir, high_data_port_out, high_data_port_dir} = 32'h3C0F00F0;
    {low_addr_port_out, low_addr_port_dir, mid_addr_port_out, mid_addr_port_dir} = 32'h000081FF;
    {upper_addr_port_out, upper_addr_port_dir, la_ext, ext_wdata} = {10'h15F, 8'h96, 16'hA55A};
    ext_addr = 21'h1BC35A;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (5) settle();
    chk(low_data_port_pins_oe, 8'h0F);
    chk({low_data_port_pins_pu, high_data_port_pins_pu}, 16'h700C);
    chk({high_data_port_pins_oe, low_addr_port_pins_pu}, 16'hF0A5);
    chk({low_addr_port_pins_oe, low_addr_port_in}, 16'h0096);
    chk({mid_addr_port_pins_out, 3'h0, upper_addr_port_pins_out}, 16'h810A);
    chk({mid_addr_port_in, 3'h0, upper_addr_port_in}, 16'h810A);
    $display("test gpio done");
    mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    settle();
    chk({low_data_port_pins_out, low_data_port_pins_oe, low_data_port_pins_pu}, 24'h5AFF00);
    chk({high_data_port_pins_oe, high_data_port_pins_pu}, 16'hF00C);
    chk({low_addr_port_pins_out, low_addr_port_pins_oe, low_addr_port_pins_pu}, 24'h5AFF00);
    chk({mid_addr_port_pins_out, 3'h0, upper_addr_port_pins_out}, 16'h810A);
    $display("test bus8 done");
    mode(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    pwm_pin_en <= 5'h1F;
    pulse_width_outputs <= 5'h15;
    settle();
    chk({high_data_port_pins_out, high_data_port_pins_oe}, 16'hA5FF);
    chk({mid_addr_port_pins_out, mid_addr_port_pins_oe}, 16'hC3FF);
    chk({upper_addr_port_pins_out, upper_addr_port_pins_oe}, 10'h37F);
    mode(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    rd_en <= 1'b1;
    rd_val <= 16'h6E39;
    settle();
    settle();
    chk({ext_rdata, low_data_port_pins_oe}, 24'h6E3900);
    chk({low_data_port_in, high_data_port_in}, 16'h396E);
    $display("test bus16 done");
    mode(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    rd_en <= 1'b0;
    pwm_pin_en <= 5'h05;
    settle();
    chk({upper_addr_port_pins_out, upper_addr_port_pins_oe}, 10'h1FF);
    mode(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    settle();
    chk({upper_addr_port_pins_out, upper_addr_port_pins_oe}, 10'h1FF);
    chk(ext_rdata, 16'h0000);
    chk({mid_addr_port_pins_out, mid_addr_port_pins_oe}, 16'h81FF);
    chk(high_data_port_pins_oe, 8'hF0);
    $display("test pulse done");
    close_out();
  end

  initial begin
    #20000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
